// ### pkg/rtcnt_consts.svh
`ifndef RTCNT_CONSTS_SVH
`define RTCNT_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTCNT_IDX_PRESCALE_CONTROL 6'h00
`define RTCNT_IDX_SYNC_STATUS      6'h01
`define RTCNT_IDX_IRQ_MASK         6'h02
`define RTCNT_IDX_IRQ_FLAGS        6'h03
`define RTCNT_IDX_EVENT_ENABLE     6'h05
`define RTCNT_IDX_COUNT_VALUE      6'h08
`define RTCNT_IDX_TOP_VALUE        6'h0a
`define RTCNT_IDX_COMPARE_VALUE    6'h0c

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define RTCNT_PRESC_W      3
`define RTCNT_BUSY_BIT     0
`define RTCNT_WRAP_BIT     0
`define RTCNT_MATCH_BIT    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCNT_RST_PRESC    3'h0
`define RTCNT_RST_COUNT    16'h0000
`define RTCNT_RST_TOP      16'hffff
`define RTCNT_RST_COMPARE  16'h0000

// ----------------------------------------------------------------
// Prescale codes
// ----------------------------------------------------------------
`define RTCNT_PS_OFF       3'h0
`define RTCNT_PS_DIV1      3'h1
`define RTCNT_PS_DIV2      3'h2
`define RTCNT_PS_DIV8      3'h3
`define RTCNT_PS_DIV16     3'h4
`define RTCNT_PS_DIV64     3'h5
`define RTCNT_PS_DIV256    3'h6
`define RTCNT_PS_DIV1024   3'h7

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define RTCNT_RESP_OKAY    2'h0
`define RTCNT_RESP_SLVERR  2'h2

`endif

// ### pkg/rtcnt_pkg.sv
`default_nettype none
package rtcnt_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic match;
      logic wrap;
   } rtcnt_evt_t;

   typedef enum logic [1:0] {
      RTCNT_SYNC_IDLE  = 2'b00,
      RTCNT_SYNC_WAIT1 = 2'b01,
      RTCNT_SYNC_WAIT2 = 2'b10
   } rtcnt_sync_t;

   typedef struct packed {
      logic presc;
      logic count;
      logic top;
      logic cmp;
   } rtcnt_pend_t;

endpackage : rtcnt_pkg
`default_nettype wire

// ### hdl/rtcnt_top.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "rtcnt_consts.svh"
`default_nettype none
module rtcnt_top #(
   parameter int CNT_W   = 16,                        // Counter width
   parameter int PRESC_W = 10                         // Prescaler width
) (
   input  wire logic        aclk,                     // System clock
   input  wire logic        aresetn,                  // Sync reset, low
   input  wire logic        ref_clk,                  // Counter reference, counted on rising edges
   input  wire logic        match_vec_ack,            // Match vector taken
   input  wire logic        wrap_vec_ack,             // Wrap vector taken
   output logic             irq,                      // Level interrupt
   output rtcnt_pkg::rtcnt_evt_t evt,                 // Event pulses
   input  wire logic [7:0]  s_axi_awaddr,             // Write address
   input  wire logic        s_axi_awvalid,            // Write address valid
   output logic             s_axi_awready,            // Write address ready
   input  wire logic [31:0] s_axi_wdata,              // Write data
   input  wire logic [3:0]  s_axi_wstrb,              // Write strobes
   input  wire logic        s_axi_wvalid,             // Write data valid
   output logic             s_axi_wready,             // Write data ready
   output logic [1:0]       s_axi_bresp,              // Write response
   output logic             s_axi_bvalid,             // Write response valid
   input  wire logic        s_axi_bready,             // Write response ready
   input  wire logic [7:0]  s_axi_araddr,             // Read address
   input  wire logic        s_axi_arvalid,            // Read address valid
   output logic             s_axi_arready,            // Read address ready
   output logic [31:0]      s_axi_rdata,              // Read data
   output logic [1:0]       s_axi_rresp,              // Read response
   output logic             s_axi_rvalid,             // Read valid
   input  wire logic        s_axi_rready              // Read ready
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] code);
      case (code)
         `RTCNT_PS_DIV2:    presc_mask = PRESC_W'(10'h001);
         `RTCNT_PS_DIV8:    presc_mask = PRESC_W'(10'h007);
         `RTCNT_PS_DIV16:   presc_mask = PRESC_W'(10'h00f);
         `RTCNT_PS_DIV64:   presc_mask = PRESC_W'(10'h03f);
         `RTCNT_PS_DIV256:  presc_mask = PRESC_W'(10'h0ff);
         `RTCNT_PS_DIV1024: presc_mask = PRESC_W'(10'h3ff);
         default:           presc_mask = PRESC_W'(10'h000);
      endcase
   endfunction : presc_mask

   // Returns {fire, next divider state}
   function automatic logic [2:0] decim(input logic [1:0] d, input logic [CNT_W-1:0] top);
      if (top == CNT_W'(0)) begin
         decim = (d == 2'h2) ? 3'h4 : {1'b0, d + 2'h1};
      end else if (top == CNT_W'(1)) begin
         decim = (d == 2'h1) ? 3'h4 : 3'h1;
      end else begin
         decim = 3'h4;
      end
   endfunction : decim

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                  ref_prev_ff;
   logic [PRESC_W-1:0]    presc_cnt_ff;
   logic [2:0]            presc_ff, pend_presc_ff;
   logic [CNT_W-1:0]      count_value_ff, top_value_ff, cmp_value_ff;
   logic [CNT_W-1:0]      pend_count_ff, pend_top_ff, pend_cmp_ff;
   rtcnt_pkg::rtcnt_pend_t pend_ff;
   rtcnt_pkg::rtcnt_sync_t sync_ff;
   logic                  domain_transfer_pending_ff;
   logic [1:0]            irq_mask_ff, evt_en_ff, flags_ff, nxt_flags;
   logic [1:0]            dec_match_ff, dec_wrap_ff;
   logic [2:0]            dm, dw;
   logic                  irq_ff;
   rtcnt_pkg::rtcnt_evt_t evt_ff;
   logic                  ref_edge, tick, match_hit, wrap_hit, apply, wr_sync;
   logic                  aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
   logic [5:0]            aw_idx_ff;
   logic [31:0]           wdata_ff;
   logic [3:0]            wstrb_ff;
   logic [1:0]            bresp_ff, rresp_ff;
   logic                  arready_ff, rvalid_ff;
   logic [31:0]           rdata_ff, wr_word, rd_word;
   logic                  do_wr, rd_hit, wr_hit;
   logic [5:0]            ar_idx;

   // ----------------------------------------------------------------
   // Reference edge and prescaler
   // ----------------------------------------------------------------
   assign ref_edge = ref_clk & ~ref_prev_ff;
   assign tick     = ref_edge && (presc_ff != `RTCNT_PS_OFF) &&
                     ((presc_cnt_ff & presc_mask(presc_ff)) == presc_mask(presc_ff));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_prev_ff  <= 1'b0;
         presc_cnt_ff <= '0;
      end else begin
         ref_prev_ff <= ref_clk;
         if (ref_edge && presc_ff != `RTCNT_PS_OFF) begin
            presc_cnt_ff <= presc_cnt_ff + PRESC_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   assign wrap_hit  = tick && (count_value_ff == top_value_ff);
   assign match_hit = tick && (count_value_ff == cmp_value_ff) &&
                      (cmp_value_ff <= top_value_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value_ff <= `RTCNT_RST_COUNT;
         top_value_ff   <= `RTCNT_RST_TOP;
         cmp_value_ff   <= `RTCNT_RST_COMPARE;
         presc_ff       <= `RTCNT_RST_PRESC;
      end else begin
         if (apply && pend_ff.count) begin
            count_value_ff <= pend_count_ff;
         end else if (wrap_hit) begin
            count_value_ff <= '0;
         end else if (tick) begin
            count_value_ff <= count_value_ff + CNT_W'(1);
         end
         if (apply && pend_ff.top) begin
            top_value_ff <= pend_top_ff;
         end
         if (apply && pend_ff.cmp) begin
            cmp_value_ff <= pend_cmp_ff;
         end
         if (apply && pend_ff.presc) begin
            presc_ff <= pend_presc_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Domain transfer handshake
   // ----------------------------------------------------------------
   assign apply = (sync_ff == rtcnt_pkg::RTCNT_SYNC_WAIT2) && ref_edge && !wr_sync;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_ff                    <= rtcnt_pkg::RTCNT_SYNC_IDLE;
         domain_transfer_pending_ff <= 1'b0;
      end else begin
         case (sync_ff)
            rtcnt_pkg::RTCNT_SYNC_IDLE: begin
               if (wr_sync) begin
                  sync_ff <= rtcnt_pkg::RTCNT_SYNC_WAIT1;
               end
            end
            rtcnt_pkg::RTCNT_SYNC_WAIT1: begin
               if (wr_sync) begin
                  sync_ff <= rtcnt_pkg::RTCNT_SYNC_WAIT1;
               end else if (ref_edge) begin
                  sync_ff <= rtcnt_pkg::RTCNT_SYNC_WAIT2;
               end
            end
            rtcnt_pkg::RTCNT_SYNC_WAIT2: begin
               if (wr_sync) begin
                  sync_ff <= rtcnt_pkg::RTCNT_SYNC_WAIT1;
               end else if (ref_edge) begin
                  sync_ff <= rtcnt_pkg::RTCNT_SYNC_IDLE;
               end
            end
            default: sync_ff <= rtcnt_pkg::RTCNT_SYNC_IDLE;
         endcase
         domain_transfer_pending_ff <= wr_sync ||
            ((sync_ff != rtcnt_pkg::RTCNT_SYNC_IDLE) && !apply);
      end
   end

   // ----------------------------------------------------------------
   // Flags, interrupt and events
   // ----------------------------------------------------------------
   assign dm = decim(dec_match_ff, top_value_ff);
   assign dw = decim(dec_wrap_ff, top_value_ff);

   always_comb begin
      nxt_flags = flags_ff;
      if (match_vec_ack) begin
         nxt_flags[`RTCNT_MATCH_BIT] = 1'b0;
      end
      if (wrap_vec_ack) begin
         nxt_flags[`RTCNT_WRAP_BIT] = 1'b0;
      end
      if (do_wr && aw_idx_ff == `RTCNT_IDX_IRQ_FLAGS && wstrb_ff[0]) begin
         nxt_flags = nxt_flags & ~wdata_ff[1:0];
      end
      if (match_hit) begin
         nxt_flags[`RTCNT_MATCH_BIT] = 1'b1;
      end
      if (wrap_hit) begin
         nxt_flags[`RTCNT_WRAP_BIT] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_ff     <= 2'h0;
         irq_ff       <= 1'b0;
         evt_ff       <= '0;
         dec_match_ff <= 2'h0;
         dec_wrap_ff  <= 2'h0;
      end else begin
         flags_ff   <= nxt_flags;
         irq_ff     <= |(flags_ff & irq_mask_ff);
         evt_ff.match <= match_hit && dm[2] && evt_en_ff[`RTCNT_MATCH_BIT];
         evt_ff.wrap  <= wrap_hit && dw[2] && evt_en_ff[`RTCNT_WRAP_BIT];
         if (match_hit) begin
            dec_match_ff <= dm[1:0];
         end
         if (wrap_hit) begin
            dec_wrap_ff <= dw[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write
   // ----------------------------------------------------------------
   assign do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wr_hit  = (aw_idx_ff == `RTCNT_IDX_PRESCALE_CONTROL) ||
                    (aw_idx_ff == `RTCNT_IDX_SYNC_STATUS) ||
                    (aw_idx_ff == `RTCNT_IDX_IRQ_MASK) ||
                    (aw_idx_ff == `RTCNT_IDX_IRQ_FLAGS) ||
                    (aw_idx_ff == `RTCNT_IDX_EVENT_ENABLE) ||
                    (aw_idx_ff == `RTCNT_IDX_COUNT_VALUE) ||
                    (aw_idx_ff == `RTCNT_IDX_TOP_VALUE) ||
                    (aw_idx_ff == `RTCNT_IDX_COMPARE_VALUE);
   assign wr_sync = do_wr && ((aw_idx_ff == `RTCNT_IDX_PRESCALE_CONTROL) ||
                    (aw_idx_ff == `RTCNT_IDX_COUNT_VALUE) ||
                    (aw_idx_ff == `RTCNT_IDX_TOP_VALUE) ||
                    (aw_idx_ff == `RTCNT_IDX_COMPARE_VALUE));
   assign wr_word = merge(32'h0000_0000, wdata_ff, wstrb_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RTCNT_RESP_OKAY;
         aw_idx_ff  <= 6'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
      end else begin
         awready_ff <= !aw_got_ff && !(s_axi_awvalid && awready_ff) && !bvalid_ff;
         wready_ff  <= !w_got_ff && !(s_axi_wvalid && wready_ff) && !bvalid_ff;
         if (s_axi_awvalid && awready_ff) begin
            aw_got_ff <= 1'b1;
            aw_idx_ff <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && wready_ff) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `RTCNT_RESP_OKAY : `RTCNT_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff       <= '0;
         pend_presc_ff <= `RTCNT_RST_PRESC;
         pend_count_ff <= `RTCNT_RST_COUNT;
         pend_top_ff   <= `RTCNT_RST_TOP;
         pend_cmp_ff   <= `RTCNT_RST_COMPARE;
         irq_mask_ff   <= 2'h0;
         evt_en_ff     <= 2'h0;
      end else begin
         if (apply) begin
            pend_ff <= '0;
         end
         if (do_wr) begin
            case (aw_idx_ff)
               `RTCNT_IDX_PRESCALE_CONTROL: begin
                  pend_presc_ff <= wr_word[`RTCNT_PRESC_W-1:0];
                  pend_ff.presc <= 1'b1;
               end
               `RTCNT_IDX_COUNT_VALUE: begin
                  pend_count_ff <= wr_word[CNT_W-1:0];
                  pend_ff.count <= 1'b1;
               end
               `RTCNT_IDX_TOP_VALUE: begin
                  pend_top_ff <= wr_word[CNT_W-1:0];
                  pend_ff.top <= 1'b1;
               end
               `RTCNT_IDX_COMPARE_VALUE: begin
                  pend_cmp_ff <= wr_word[CNT_W-1:0];
                  pend_ff.cmp <= 1'b1;
               end
               `RTCNT_IDX_IRQ_MASK:     irq_mask_ff <= wr_word[1:0];
               `RTCNT_IDX_EVENT_ENABLE: evt_en_ff   <= wr_word[1:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read
   // ----------------------------------------------------------------
   assign ar_idx = s_axi_araddr[7:2];

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (ar_idx)
         `RTCNT_IDX_PRESCALE_CONTROL: rd_word[`RTCNT_PRESC_W-1:0] = presc_ff;
         `RTCNT_IDX_SYNC_STATUS:   rd_word[`RTCNT_BUSY_BIT] = domain_transfer_pending_ff;
         `RTCNT_IDX_IRQ_MASK:      rd_word[1:0] = irq_mask_ff;
         `RTCNT_IDX_IRQ_FLAGS:     rd_word[1:0] = flags_ff;
         `RTCNT_IDX_EVENT_ENABLE:  rd_word[1:0] = evt_en_ff;
         `RTCNT_IDX_COUNT_VALUE:   rd_word[CNT_W-1:0] = count_value_ff;
         `RTCNT_IDX_TOP_VALUE:     rd_word[CNT_W-1:0] = top_value_ff;
         `RTCNT_IDX_COMPARE_VALUE: rd_word[CNT_W-1:0] = cmp_value_ff;
         default:                  rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `RTCNT_RESP_OKAY;
      end else begin
         arready_ff <= !rvalid_ff && !(s_axi_arvalid && arready_ff);
         if (s_axi_arvalid && arready_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_hit ? `RTCNT_RESP_OKAY : `RTCNT_RESP_SLVERR;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign irq           = irq_ff;
   assign evt           = evt_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

endmodule : rtcnt_top
`default_nettype wire

// ### testbench/rtcnt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rtcnt_chk (
   input wire logic                  aclk,          // Clock
   input wire logic                  aresetn,       // Reset
   input wire logic                  ref_clk,       // Reference
   input wire logic                  irq,           // Interrupt
   input wire rtcnt_pkg::rtcnt_evt_t evt,           // Events
   input wire logic                  s_axi_awvalid, // Bus
   input wire logic                  s_axi_awready, // Bus
   input wire logic                  s_axi_wvalid,  // Bus
   input wire logic                  s_axi_wready,  // Bus
   input wire logic                  s_axi_bvalid,  // Bus
   input wire logic                  s_axi_arvalid, // Bus
   input wire logic                  s_axi_arready, // Bus
   input wire logic                  s_axi_rvalid,  // Bus
   input wire logic [1:0]            s_axi_rresp,   // Bus
   input wire logic [31:0]           s_axi_rdata    // Bus
);
   logic       ref_q_ff;
   logic [3:0] since_ff;

   // ----------------------------------------------------------------
   // Cycles since the last reference rise
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_q_ff <= 1'b0;
         since_ff <= 4'hf;
      end else begin
         ref_q_ff <= ref_clk;
         if (ref_clk && !ref_q_ff) since_ff <= 4'h0;
         else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]; endproperty
   a_aw_drop: assert property (p_aw_drop) else $error("write address ready too early");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read address ready during answer");
   property p_unmapped; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("error read carries data");
   property p_wrap_pulse; evt.wrap |=> !evt.wrap; endproperty
   a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap event too long");
   property p_match_pulse; evt.match |=> !evt.match; endproperty
   a_match_pulse: assert property (p_match_pulse) else $error("match event too long");
   property p_evt_ref; evt != 2'h0 |-> since_ff <= 4'h4; endproperty
   a_evt_ref: assert property (p_evt_ref) else $error("event without reference edge");
   c_wrap: cover property (evt.wrap);
   c_match: cover property (evt.match);
   c_irq: cover property ($rose(irq));
endmodule : rtcnt_chk
`default_nettype wire

// ### testbench/rtcnt_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcnt_consts.svh"
module rtcnt_top_test;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  r;
   } rtcnt_row_t;
   localparam logic [7:0] A_PS = {`RTCNT_IDX_PRESCALE_CONTROL, 2'h0};
   localparam logic [7:0] A_ST = {`RTCNT_IDX_SYNC_STATUS, 2'h0};
   localparam logic [7:0] A_MK = {`RTCNT_IDX_IRQ_MASK, 2'h0};
   localparam logic [7:0] A_FL = {`RTCNT_IDX_IRQ_FLAGS, 2'h0};
   localparam logic [7:0] A_EV = {`RTCNT_IDX_EVENT_ENABLE, 2'h0};
   localparam logic [7:0] A_CN = {`RTCNT_IDX_COUNT_VALUE, 2'h0};
   localparam logic [7:0] A_TP = {`RTCNT_IDX_TOP_VALUE, 2'h0};
   localparam logic [7:0] A_CP = {`RTCNT_IDX_COMPARE_VALUE, 2'h0};
   localparam int DIVS [8] = '{4, 1, 2, 8, 16, 64, 256, 1024};
   localparam rtcnt_row_t ROWS [9] = '{'{A_PS, 32'h0, 2'h0}, '{A_ST, 32'h0, 2'h0},
      '{A_MK, 32'h0, 2'h0}, '{A_FL, 32'h0, 2'h0}, '{A_EV, 32'h0, 2'h0}, '{A_CN, 32'h0, 2'h0},
      '{A_TP, 32'h0000ffff, 2'h0}, '{A_CP, 32'h0, 2'h0}, '{8'h3c, 32'h0, 2'h2}};
   logic        aclk = 1'b0, aresetn = 1'b0, ref_clk = 1'b0, irq;
   logic        match_vec_ack = 1'b0, wrap_vec_ack = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   rtcnt_pkg::rtcnt_evt_t evt;
   int          miscompares = 0, comparisons = 0, nw = 0, nm = 0, cycles = 0;

   rtcnt_top dut_u (.aclk, .aresetn, .ref_clk, .match_vec_ack, .wrap_vec_ack, .irq, .evt,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (evt.wrap === 1'b1) nw++;
      if (evt.match === 1'b1) nm++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm_s, e, g);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      bit aw = 1'b0;
      bit w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awready) aw = 1'b1;
         if (s_axi_wready) w = 1'b1;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask : axw
   task automatic rdc(input string nm_s, input logic [7:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      r = s_axi_rresp;
      chk(nm_s, e, s_axi_rdata);
   endtask : rdc
   task automatic edges(input int n);
      repeat (n) begin
         ref_clk <= 1'b1;
         repeat (2) @(posedge aclk);
         ref_clk <= 1'b0;
         repeat (2) @(posedge aclk);
      end
   endtask : edges
   task automatic sw(input logic [7:0] a, input logic [31:0] v);
      axw(a, v);
      edges(2);
      rdc("busy", A_ST, 32'h0);
   endtask : sw
   task automatic hits(input int n, input int ew, input int em);
      int w0 = nw;
      int m0 = nm;
      edges(n);
      repeat (3) @(posedge aclk);
      chk("wrap events", ew, nw - w0);
      chk("match events", em, nm - m0);
   endtask : hits

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      chk("reset irq", 32'h0, {31'h0, irq});
      chk("reset evt", 32'h0, {30'h0, evt});
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      foreach (ROWS[i]) begin
         rdc("reset value", ROWS[i].a, ROWS[i].d);
         chk("read resp", {30'h0, ROWS[i].r}, {30'h0, r});
      end
      axw(8'h3c, 32'h1);
      chk("unmapped write", 32'h2, {30'h0, r});
      axw(A_TP, 32'h2);
      rdc("busy set", A_ST, 32'h1);
      rdc("top before sync", A_TP, 32'h0000ffff);
      edges(2);
      rdc("busy clear", A_ST, 32'h0);
      rdc("top after sync", A_TP, 32'h2);
      for (int c = 0; c < 8; c++) begin
         sw(A_PS, 32'(c));
         sw(A_CN, 32'h0);
         edges(c == 0 ? DIVS[0] : 2 * DIVS[c]);
         rdc("count", A_CN, (c == 0) ? 32'h0 : 32'h2);
      end
      sw(A_PS, 32'h1);
      axw(A_MK, 32'h3);
      axw(A_EV, 32'h3);
      sw(A_CP, 32'h1);
      sw(A_CN, 32'h0);
      hits(6, 2, 2);
      rdc("count", A_CN, 32'h0);
      rdc("flags", A_FL, 32'h3);
      chk("irq", 32'h1, {31'h0, irq});
      axw(A_FL, 32'h2);
      rdc("flags w1c", A_FL, 32'h1);
      wrap_vec_ack <= 1'b1;
      @(posedge aclk);
      wrap_vec_ack <= 1'b0;
      rdc("flags ack", A_FL, 32'h0);
      axw(A_MK, 32'h0);
      edges(3);
      rdc("flags masked", A_FL, 32'h3);
      chk("irq masked", 32'h0, {31'h0, irq});
      match_vec_ack <= 1'b1;
      @(posedge aclk);
      match_vec_ack <= 1'b0;
      rdc("flags ack", A_FL, 32'h1);
      sw(A_CP, 32'h5);
      sw(A_TP, 32'h1);
      sw(A_CN, 32'h0);
      hits(8, 2, 0);
      sw(A_CP, 32'h0);
      sw(A_TP, 32'h0);
      hits(6, 2, 2);
      axw(A_EV, 32'h2);
      hits(6, 0, 2);
      sw(A_PS, 32'h0);
      hits(6, 0, 0);
      close_out();
   end
endmodule : rtcnt_top_test

bind rtcnt_top rtcnt_chk chk_u (.aclk, .aresetn, .ref_clk, .irq, .evt, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata);
`default_nettype wire
